// *** verilog/sct_params.svh ***
// Constants for the transported-command interpreter.
// Assumes nothing beyond inclusion by the package and design files.
`ifndef SCT_PARAMS_SVH
`define SCT_PARAMS_SVH
`define SCT_OP_WRLOGX 8'h3f
`define SCT_PAGE_CMD 8'he0
`define SCT_PAGE_DATA 8'he1
`define SCT_CNT_CUR 8'h01
`define SCT_ZERO8 8'h00
`define SCT_ERR_OK 8'h00
`define SCT_ERR_ABRT 8'h04
`define SCT_STAT_OK 8'h50
`define SCT_STAT_ERR 8'h51
`define SCT_PKT_WORDS 256
`define SCT_PKT_BYTES 512
`define SCT_AC_LONG 16'h0001
`define SCT_AC_WSAME 16'h0002
`define SCT_AC_ERC 16'h0003
`define SCT_AC_FEAT 16'h0004
`define SCT_AC_TABLE 16'h0005
`define SCT_AC_VEND 16'hc000
`define SCT_XS_OK 16'h0000
`define SCT_XS_BADAC 16'h0010
`define SCT_XS_BADCNT 16'h0003
`define SCT_XS_NOCMD 16'h000b
`define SCT_PARAM_WORD 2
`endif

// *** verilog/sct_pkg.sv ***
// Types for the transported-command interpreter.
// Assumes the constants header is on the include path.
`include "sct_params.svh"
package sct_pkg;
    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] feat_cur;
        logic [7:0] feat_prev;
        logic [7:0] cnt_cur;
        logic [7:0] cnt_prev;
        logic [7:0] lba_lo_cur;
        logic [7:0] lba_lo_prev;
        logic [7:0] lba_mid_cur;
        logic [7:0] lba_mid_prev;
        logic [7:0] lba_hi_cur;
        logic [7:0] lba_hi_prev;
    } sct_tf_t;
    typedef struct packed {
        logic [7:0] err;
        logic [7:0] cnt;
        logic [7:0] lba_lo;
        logic [7:0] lba_mid;
        logic [7:0] lba_hi;
        logic [7:0] stat;
        logic [7:0] cnt_hob;
        logic [7:0] lba_lo_hob;
        logic [7:0] lba_mid_hob;
        logic [7:0] lba_hi_hob;
    } sct_resp_t;
    typedef struct packed {
        logic [15:0] action;
        logic [15:0] func;
        logic [15:0] xstat;
        logic [15:0] nsect;
        logic ok;
    } sct_exec_t;
    typedef enum logic [2:0] {
        SCT_IDLE, SCT_RECV, SCT_EXEC, SCT_WAIT, SCT_DONE
    } sct_state_t;
    typedef enum logic [2:0] {
        SCT_ACT_NONE, SCT_ACT_WSAME, SCT_ACT_ERC, SCT_ACT_FEAT, SCT_ACT_TABLE, SCT_ACT_VEND
    } sct_act_t;
endpackage

// *** verilog/sct_param_ram.sv ***
// Parameter store for the command packet words, registered read port.
// Assumes a single clock shared with the interpreter.
`timescale 1ns/1ps
`default_nettype none
module sct_param_ram #(
    parameter int DEPTH = 256,
    parameter int AW = 8
) (
    // Clock and enable.
    input wire logic core_clk_in,
    input wire logic ce_in,
    // Write port.
    input wire logic wr_en_in,
    input wire logic [AW-1:0] wr_addr_in,
    input wire logic [15:0] wr_data_in,
    // Read port.
    input wire logic [AW-1:0] rd_addr_in,
    output logic [15:0] rd_data_out
);
    logic [15:0] mem [DEPTH];
    initial begin
        if (DEPTH > (1 << AW)) $error("sct_param_ram: depth exceeds address range");
    end
    always_ff @(posedge core_clk_in) begin
        if (ce_in) begin
            if (wr_en_in) begin
                mem[wr_addr_in] <= wr_data_in;
            end
            rd_data_out <= mem[rd_addr_in];
        end
    end
endmodule
`default_nettype wire

// *** verilog/sct_skid_buf.sv ***
// Two-entry buffer with valid and ready on both sides.
// Assumes source and sink share the interpreter's clock.
`timescale 1ns/1ps
`default_nettype none
module sct_skid_buf #(
    parameter int WIDTH = 16
) (
    // Clock, reset and enable.
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    // Fill side.
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    // Drain side.
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    typedef struct packed {
        logic [1:0][WIDTH-1:0] data;
        logic [1:0] cnt;
    } sct_buf_t;
    sct_buf_t st_reg, st_next;
    initial begin
        if (WIDTH < 1) $error("sct_skid_buf: width must be positive");
    end
    assign in_ready_out = (st_reg.cnt != 2'h2);
    assign out_valid_out = (st_reg.cnt != 2'h0);
    assign out_data_out = st_reg.data[0];
    always_comb begin
        logic push;
        logic pop;
        push = in_valid_in && in_ready_out;
        pop = out_valid_out && out_ready_in;
        st_next = st_reg;
        if (pop) begin
            st_next.data[0] = st_reg.data[1];
        end
        if (push) begin
            if (st_reg.cnt == 2'h0 || (st_reg.cnt == 2'h1 && pop)) begin
                st_next.data[0] = in_data_in;
            end else begin
                st_next.data[1] = in_data_in;
            end
        end
        st_next.cnt = st_reg.cnt + {1'b0, push} - {1'b0, pop};
    end
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_reg <= '0;
        end else if (ce_in) begin
            st_reg <= st_next;
        end
    end
endmodule
`default_nettype wire

// *** verilog/sct_cmd_issue.sv ***
// Interpreter for transported commands written as an extended log write to the command page.
// Assumes the host task file arrives synchronous to core_clk_in, and packet words
// stream in on a valid/ready channel from the device's sector buffer logic.
// Notes on behaviour
// RULE_01: Issue is opcode 3Fh, count 01h/00h, page E0h, mid 00h/00h.
// RULE_02: Success gives error 00h status 50h; failure 04h, 51h, extended status.
// RULE_03: Follow-on sector count returned in LBA mid (low) and LBA high (high).
// RULE_04: All previous halves of the response are reserved and read zero.
// RULE_05: The command packet is exactly 512 bytes.
// RULE_06: Bytes 1:0 form the action code choosing the command type.
// RULE_07: Bytes 3:2 form the function code choosing the access type.
// RULE_08: Parameters begin at byte 4; the packet spans 256 words.
// RULE_09: Action codes 2-5 supported, 0 and 6-BFFFh reserved, C000h+ vendor.
// RULE_10: Action code 0001h, long sector access, is never executed.
// RULE_11: An invalid action code fails with extended status 0010h.
// RULE_12: Block data moves through the data page E1h, not the command page.
`timescale 1ns/1ps
`default_nettype none
`include "sct_params.svh"
module sct_cmd_issue #(
    parameter int PKT_WORDS = `SCT_PKT_WORDS
) (
    // Clock, reset and enable.
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    // Host task file command.
    input wire logic cmd_valid_in,
    input wire sct_pkg::sct_tf_t cmd_tf_in,
    output logic cmd_ready_out,
    // Packet words, byte 0 in bits 7:0.
    input wire logic pkt_valid_in,
    input wire logic [15:0] pkt_data_in,
    output logic pkt_ready_out,
    // Parameter word read-back for the action engines.
    input wire logic [7:0] param_addr_in,
    output logic [15:0] param_data_out,
    // Decoded command handed to the action engines.
    output logic exec_valid_out,
    output sct_pkg::sct_exec_t exec_out,
    output sct_pkg::sct_act_t exec_act_out,
    input wire logic exec_done_in,
    input wire logic exec_ok_in,
    input wire logic [15:0] exec_xstat_in,
    input wire logic [15:0] exec_nsect_in,
    // Response register block.
    output logic resp_valid_out,
    output sct_pkg::sct_resp_t resp_out,
    input wire logic resp_ack_in,
    // Status.
    output logic data_page_armed_out,
    output logic busy_out
);
    import sct_pkg::*;
    default clocking dcb @(posedge core_clk_in);
    endclocking
    default disable iff (!nrst_in);

    typedef struct packed {
        sct_state_t state;
        logic [8:0] widx;
        sct_exec_t ex;
        sct_act_t act;
        logic armed;
        sct_resp_t resp;
        logic resp_valid;
    } sct_st_t;

    sct_st_t st_reg, st_next;
    logic buf_valid;
    logic [15:0] buf_data;
    logic buf_ready;
    logic word_take;

    initial begin
        if (PKT_WORDS != `SCT_PKT_WORDS) $error("sct_cmd_issue: packet must be 256 words");
        if (PKT_WORDS * 2 != `SCT_PKT_BYTES) $error("sct_cmd_issue: packet must be 512 bytes");
    end

    // Packet words pass through a two-entry buffer so a stall here loses nothing.
    sct_skid_buf #(.WIDTH(16)) u_buf (
        .core_clk_in(core_clk_in),
        .nrst_in(nrst_in),
        .ce_in(ce_in),
        .in_valid_in(pkt_valid_in),
        .in_data_in(pkt_data_in),
        .in_ready_out(pkt_ready_out),
        .out_valid_out(buf_valid),
        .out_data_out(buf_data),
        .out_ready_in(buf_ready)
    );

    assign buf_ready = (st_reg.state == SCT_RECV);
    assign word_take = buf_valid && buf_ready;

    // Parameter words from byte 4 onward are kept for the action engines.
    sct_param_ram #(.DEPTH(PKT_WORDS), .AW(8)) u_ram (
        .core_clk_in(core_clk_in),
        .ce_in(ce_in),
        .wr_en_in(word_take && st_reg.widx >= 9'(`SCT_PARAM_WORD)), // RULE_08
        .wr_addr_in(st_reg.widx[7:0]),
        .wr_data_in(buf_data),
        .rd_addr_in(param_addr_in),
        .rd_data_out(param_data_out)
    );

    function automatic logic is_issue(input sct_tf_t tf);
        // RULE_01
        return tf.cmd == `SCT_OP_WRLOGX && tf.cnt_cur == `SCT_CNT_CUR &&
               tf.cnt_prev == `SCT_ZERO8 && tf.lba_lo_cur == `SCT_PAGE_CMD &&
               tf.lba_mid_cur == `SCT_ZERO8 && tf.lba_mid_prev == `SCT_ZERO8;
    endfunction

    function automatic sct_act_t decode_act(input logic [15:0] ac);
        // RULE_09 RULE_10
        if (ac >= `SCT_AC_VEND) begin
            return SCT_ACT_VEND;
        end
        case (ac)
            `SCT_AC_WSAME: return SCT_ACT_WSAME;
            `SCT_AC_ERC: return SCT_ACT_ERC;
            `SCT_AC_FEAT: return SCT_ACT_FEAT;
            `SCT_AC_TABLE: return SCT_ACT_TABLE;
            default: return SCT_ACT_NONE;
        endcase
    endfunction

    function automatic sct_resp_t make_resp(input logic ok, input logic [15:0] xs,
                                            input logic [15:0] ns);
        sct_resp_t r;
        r = '0; // RULE_04
        r.err = ok ? `SCT_ERR_OK : `SCT_ERR_ABRT; // RULE_02
        r.stat = ok ? `SCT_STAT_OK : `SCT_STAT_ERR;
        r.cnt = xs[7:0];
        r.lba_lo = xs[15:8];
        r.lba_mid = ns[7:0]; // RULE_03
        r.lba_hi = ns[15:8];
        return r;
    endfunction

    assign cmd_ready_out = (st_reg.state == SCT_IDLE) && !st_reg.resp_valid;

    always_comb begin
        st_next = st_reg;
        if (st_reg.resp_valid && resp_ack_in) begin
            st_next.resp_valid = 1'b0;
        end
        case (st_reg.state)
            SCT_IDLE: begin
                if (cmd_valid_in && cmd_ready_out) begin
                    if (is_issue(cmd_tf_in)) begin
                        st_next.state = SCT_RECV;
                        st_next.widx = '0;
                        st_next.armed = 1'b0;
                    end else if (cmd_tf_in.cmd == `SCT_OP_WRLOGX &&
                                 cmd_tf_in.lba_lo_cur == `SCT_PAGE_CMD) begin
                        // Command page write that is not a valid issue (wrong length or mid): refuse.
                        st_next.resp = make_resp(1'b0, `SCT_XS_BADCNT, 16'h0000); // RULE_05
                        st_next.resp_valid = 1'b1;
                    end else if (cmd_tf_in.cmd == `SCT_OP_WRLOGX &&
                                 cmd_tf_in.lba_lo_cur == `SCT_PAGE_DATA && !st_reg.armed) begin
                        st_next.resp = make_resp(1'b0, `SCT_XS_NOCMD, 16'h0000); // RULE_12
                        st_next.resp_valid = 1'b1;
                    end
                end
            end
            SCT_RECV: begin
                if (word_take) begin
                    if (st_reg.widx == 9'h000) begin
                        st_next.ex.action = buf_data; // RULE_06
                    end
                    if (st_reg.widx == 9'h001) begin
                        st_next.ex.func = buf_data; // RULE_07
                    end
                    st_next.widx = st_reg.widx + 9'h001;
                    if (st_reg.widx == 9'(PKT_WORDS - 1)) begin
                        st_next.state = SCT_EXEC; // RULE_05
                    end
                end
            end
            SCT_EXEC: begin
                st_next.act = decode_act(st_reg.ex.action);
                if (decode_act(st_reg.ex.action) == SCT_ACT_NONE) begin
                    st_next.resp = make_resp(1'b0, `SCT_XS_BADAC, 16'h0000); // RULE_11
                    st_next.resp_valid = 1'b1;
                    st_next.state = SCT_IDLE;
                end else begin
                    st_next.state = SCT_WAIT;
                end
            end
            SCT_WAIT: begin
                if (exec_done_in) begin
                    st_next.ex.ok = exec_ok_in;
                    st_next.ex.xstat = exec_ok_in ? `SCT_XS_OK : exec_xstat_in;
                    st_next.ex.nsect = exec_nsect_in;
                    st_next.state = SCT_DONE;
                end
            end
            SCT_DONE: begin
                st_next.resp = make_resp(st_reg.ex.ok, st_reg.ex.xstat, st_reg.ex.nsect);
                st_next.resp_valid = 1'b1;
                // When the engine reports a nonzero sector count, data for the command now goes through the data page.
                st_next.armed = (st_reg.ex.nsect != 16'h0000); // RULE_12
                st_next.state = SCT_IDLE;
            end
            default: begin
                st_next.state = SCT_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_reg <= '{state: SCT_IDLE, act: SCT_ACT_NONE, default: '0};
        end else if (ce_in) begin
            st_reg <= st_next;
        end
    end

    assign exec_valid_out = (st_reg.state == SCT_WAIT);
    assign exec_out = st_reg.ex;
    assign exec_act_out = st_reg.act;
    assign resp_valid_out = st_reg.resp_valid;
    assign resp_out = st_reg.resp;
    assign data_page_armed_out = st_reg.armed;
    assign busy_out = (st_reg.state != SCT_IDLE);

    a_bad_action: assert property (@(posedge core_clk_in) disable iff (!nrst_in) // RULE_11
        ce_in && st_reg.state == SCT_EXEC && decode_act(st_reg.ex.action) == SCT_ACT_NONE
        |=> resp_valid_out && resp_out.cnt == 8'h10 && resp_out.lba_lo == 8'h00)
        else $error("invalid action code not failed with 0010h");
    a_ok_codes: assert property (@(posedge core_clk_in) disable iff (!nrst_in) // RULE_02
        resp_valid_out |-> (resp_out.err == 8'h00 && resp_out.stat == 8'h50) ||
                           (resp_out.err == 8'h04 && resp_out.stat == 8'h51))
        else $error("bad error/status pair");
    a_hob_zero: assert property (@(posedge core_clk_in) disable iff (!nrst_in) // RULE_04
        resp_valid_out |-> resp_out.cnt_hob == 8'h00 && resp_out.lba_hi_hob == 8'h00 &&
        resp_out.lba_lo_hob == 8'h00 && resp_out.lba_mid_hob == 8'h00)
        else $error("previous half not reserved zero");
    a_long_never: assert property (@(posedge core_clk_in) disable iff (!nrst_in) // RULE_10
        exec_valid_out |-> exec_out.action != 16'h0001 && exec_out.action != 16'h0000)
        else $error("unsupported action executed");
    a_nsect_place: assert property (@(posedge core_clk_in) disable iff (!nrst_in) // RULE_03
        ce_in && st_reg.state == SCT_DONE |=>
        resp_out.lba_mid == $past(st_reg.ex.nsect[7:0]) &&
        resp_out.lba_hi == $past(st_reg.ex.nsect[15:8]))
        else $error("sector count misplaced");
    a_issue_recv: assert property (@(posedge core_clk_in) disable iff (!nrst_in) // RULE_01
        ce_in && cmd_valid_in && cmd_ready_out && cmd_tf_in.cmd == 8'h3f &&
        cmd_tf_in.cnt_cur == 8'h01 && cmd_tf_in.cnt_prev == 8'h00 &&
        cmd_tf_in.lba_lo_cur == 8'he0 && cmd_tf_in.lba_mid_cur == 8'h00 &&
        cmd_tf_in.lba_mid_prev == 8'h00 |=> st_reg.state == SCT_RECV)
        else $error("valid issue not accepted");
    a_pkt_len: assert property (@(posedge core_clk_in) disable iff (!nrst_in) // RULE_05
        st_reg.state == SCT_EXEC |-> $past(st_reg.widx) == 9'd255 || st_reg.widx == 9'd256)
        else $error("packet not 256 words");
    a_action_word: assert property (@(posedge core_clk_in) disable iff (!nrst_in) // RULE_06
        ce_in && word_take && st_reg.widx == 9'h000 |=> st_reg.ex.action == $past(buf_data))
        else $error("action code not latched from word 0");
    a_func_word: assert property (@(posedge core_clk_in) disable iff (!nrst_in) // RULE_07
        ce_in && word_take && st_reg.widx == 9'h001 |=> st_reg.ex.func == $past(buf_data))
        else $error("function code not latched from word 1");

    // An engine's completion reaches the host in two steps: latch, then raise.
    sequence s_engine_done;
        ce_in && st_reg.state == SCT_WAIT && exec_done_in;
    endsequence
    sequence s_done_step;
        ce_in && st_reg.state == SCT_DONE;
    endsequence
    sequence s_cmd_taken;
        ce_in && cmd_valid_in && cmd_ready_out && cmd_tf_in.cmd == 8'h3f;
    endsequence
    a_done_step: assert property ( // RULE_02
        s_engine_done |=> st_reg.state == SCT_DONE)
        else $error("engine completion not taken");
    a_done_resp: assert property ( // RULE_02
        s_engine_done ##1 s_done_step |=> resp_valid_out && !busy_out)
        else $error("response not raised after completion");
    a_ok_xstat: assert property ( // RULE_02
        ce_in && st_reg.state == SCT_DONE && st_reg.ex.ok |=>
        resp_out.err == 8'h00 && resp_out.cnt == 8'h00 && resp_out.lba_lo == 8'h00)
        else $error("success response carries a status code");
    a_resp_hold: assert property ( // RULE_02
        resp_valid_out && !resp_ack_in |=> resp_valid_out && $stable(resp_out))
        else $error("response dropped before acknowledge");
    a_len_refuse: assert property ( // RULE_05
        s_cmd_taken ##0 (cmd_tf_in.lba_lo_cur == 8'he0 && !is_issue(cmd_tf_in)) |=>
        resp_valid_out && resp_out.cnt == 8'h03 && resp_out.err == 8'h04)
        else $error("wrong packet length not refused");
    a_early_data: assert property ( // RULE_12
        s_cmd_taken ##0 (cmd_tf_in.lba_lo_cur == 8'he1 && !data_page_armed_out) |=>
        resp_valid_out && resp_out.cnt == 8'h0b && resp_out.lba_lo == 8'h00)
        else $error("data page write without command not refused");
    a_armed_set: assert property ( // RULE_12
        s_done_step |=> data_page_armed_out == ($past(st_reg.ex.nsect) != 16'h0000))
        else $error("data page not armed by sector count");
    a_vend_class: assert property ( // RULE_09
        exec_valid_out && exec_out.action >= 16'hc000 |-> exec_act_out == SCT_ACT_VEND)
        else $error("vendor action code not passed on");
    a_wsame_class: assert property ( // RULE_09
        exec_valid_out && exec_out.action == 16'h0002 |-> exec_act_out == SCT_ACT_WSAME)
        else $error("write same action code misclassified");
    a_exec_hold: assert property ( // RULE_09
        exec_valid_out && !exec_done_in |=> exec_valid_out && $stable(exec_out))
        else $error("engine request dropped before completion");
endmodule
`default_nettype wire

// *** tb/sct_host_model.sv ***
// Host controller model: offers task files, streams packet words, takes responses.
// Assumes the interpreter's clock and its valid/ready and valid/ack handshakes.
`timescale 1ns/1ps
`default_nettype none
module sct_host_model (
    // Clock.
    input wire logic core_clk_in,
    // Task file.
    output logic cmd_valid_out,
    output sct_pkg::sct_tf_t cmd_tf_out,
    input wire logic cmd_ready_in,
    // Packet words.
    output logic pkt_valid_out,
    output logic [15:0] pkt_data_out,
    input wire logic pkt_ready_in,
    // Response block.
    input wire logic resp_valid_in,
    input wire sct_pkg::sct_resp_t resp_in,
    output logic resp_ack_out
);
    import sct_pkg::*;
    initial begin
        cmd_valid_out = 1'b0;
        cmd_tf_out = '0;
        pkt_valid_out = 1'b0;
        pkt_data_out = 16'h0000;
        resp_ack_out = 1'b0;
    end
    function automatic logic [15:0] word_of(input int i, input logic [15:0] ac, input logic [15:0] fc);
        return (i == 0) ? ac : (i == 1) ? fc : 16'(i) ^ 16'h5a00;
    endfunction
    // Released lines show the inverse of their last value so stale data never matches.
    task automatic send_cmd(input sct_tf_t tf);
        @(posedge core_clk_in);
        cmd_valid_out <= 1'b1;
        cmd_tf_out <= tf;
        do @(posedge core_clk_in); while (cmd_ready_in !== 1'b1);
        cmd_valid_out <= 1'b0;
        cmd_tf_out <= ~tf;
    endtask
    task automatic send_pkt(input logic [15:0] ac, input logic [15:0] fc, input bit stall);
        for (int i = 0; i < 256; i++) begin
            if (stall && (i % 5 == 0)) begin
                pkt_valid_out <= 1'b0;
                pkt_data_out <= ~pkt_data_out;
                @(posedge core_clk_in);
            end
            pkt_valid_out <= 1'b1;
            pkt_data_out <= word_of(i, ac, fc);
            do @(posedge core_clk_in); while (pkt_ready_in !== 1'b1);
        end
        pkt_valid_out <= 1'b0;
        pkt_data_out <= ~pkt_data_out;
    endtask
    task automatic take_resp(output sct_resp_t r);
        do @(posedge core_clk_in); while (resp_valid_in !== 1'b1);
        r = resp_in;
        resp_ack_out <= 1'b1;
        @(posedge core_clk_in);
        resp_ack_out <= 1'b0;
    endtask
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the transported-command interpreter.
// Assumes the host model file and the design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "sct_params.svh"
module tb;
    import sct_pkg::*;
    logic core_clk_in, nrst_in, cmd_valid_in, cmd_ready_out, pkt_valid_in, pkt_ready_out;
    logic exec_valid_out, exec_done_in, exec_ok_in, resp_valid_out, resp_ack_in;
    logic data_page_armed_out, busy_out;
    logic [15:0] pkt_data_in, param_data_out, exec_xstat_in, exec_nsect_in;
    logic [7:0] param_addr_in;
    sct_tf_t cmd_tf_in;
    sct_exec_t exec_out;
    sct_act_t exec_act_out;
    sct_resp_t r, resp_out_w;
    int n_errors, checks_done, cycles, n_exec, exec_mark;
    logic [15:0] good_ac [6] = '{16'h0002, 16'h0003, 16'h0004, 16'h0005, 16'hc000, 16'hffff};
    sct_act_t good_act [6] = '{SCT_ACT_WSAME, SCT_ACT_ERC, SCT_ACT_FEAT, SCT_ACT_TABLE,
                              SCT_ACT_VEND, SCT_ACT_VEND};
    logic [15:0] bad_ac [4] = '{16'h0000, 16'h0001, 16'h0006, 16'hbfff};

    sct_cmd_issue #(.PKT_WORDS(256)) uut (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
        .ce_in(1'b1), .cmd_valid_in(cmd_valid_in), .cmd_tf_in(cmd_tf_in),
        .cmd_ready_out(cmd_ready_out), .pkt_valid_in(pkt_valid_in), .pkt_data_in(pkt_data_in),
        .pkt_ready_out(pkt_ready_out), .param_addr_in(param_addr_in),
        .param_data_out(param_data_out), .exec_valid_out(exec_valid_out), .exec_out(exec_out),
        .exec_act_out(exec_act_out), .exec_done_in(exec_done_in), .exec_ok_in(exec_ok_in),
        .exec_xstat_in(exec_xstat_in), .exec_nsect_in(exec_nsect_in),
        .resp_valid_out(resp_valid_out), .resp_out(resp_out_w), .resp_ack_in(resp_ack_in),
        .data_page_armed_out(data_page_armed_out), .busy_out(busy_out));
    sct_host_model host (.core_clk_in(core_clk_in), .cmd_valid_out(cmd_valid_in),
        .cmd_tf_out(cmd_tf_in), .cmd_ready_in(cmd_ready_out), .pkt_valid_out(pkt_valid_in),
        .pkt_data_out(pkt_data_in), .pkt_ready_in(pkt_ready_out),
        .resp_valid_in(resp_valid_out), .resp_in(resp_out_w), .resp_ack_out(resp_ack_in));

    initial begin
        core_clk_in = 1'b0;
        forever #2.5 core_clk_in = ~core_clk_in;
    end
    // Watchdog: a hang counts as a mismatch and closes the run.
    always @(posedge core_clk_in) begin
        cycles <= cycles + 1;
        if (exec_valid_out === 1'b1) n_exec <= n_exec + 1;
        if (cycles == 20000) begin
            n_errors++;
            end_of_test();
        end
    end
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    function automatic sct_tf_t tf_of(input logic [7:0] op, input logic [7:0] cnt, input logic [7:0] pg);
        sct_tf_t t;
        t = '0;
        t.cmd = op;
        t.cnt_cur = cnt;
        t.lba_lo_cur = pg;
        return t;
    endfunction
    task automatic chk_resp(input logic ok, input logic [15:0] xs);
        chk("err", {8'h00, r.err}, {8'h00, ok ? `SCT_ERR_OK : `SCT_ERR_ABRT});
        chk("stat", {8'h00, r.stat}, {8'h00, ok ? `SCT_STAT_OK : `SCT_STAT_ERR});
        chk("xstat", {r.lba_lo, r.cnt}, ok ? 16'h0000 : xs);
        chk("hob", {r.cnt_hob | r.lba_lo_hob, r.lba_mid_hob | r.lba_hi_hob}, 16'h0000);
    endtask
    task automatic refusal(input sct_tf_t tf, input logic [15:0] xs);
        host.send_cmd(tf);
        host.take_resp(r);
        chk_resp(1'b0, xs);
    endtask
    task automatic run_cmd(input logic [15:0] ac, input int k, input bit bad);
        logic [15:0] fc, ns;
        fc = 16'h0100 + 16'(k);
        ns = {8'(k + 1), 8'h30};
        exec_mark = n_exec;
        host.send_cmd(tf_of(`SCT_OP_WRLOGX, `SCT_CNT_CUR, `SCT_PAGE_CMD));
        @(posedge core_clk_in);
        #1 chk("ready while busy", 16'({busy_out, cmd_ready_out}), 16'h0002);
        @(posedge core_clk_in);
        host.send_pkt(ac, fc, k[0]);
        if (bad) begin
            host.take_resp(r);
            chk_resp(1'b0, `SCT_XS_BADAC);
            chk("engine start", 16'(n_exec - exec_mark), 16'h0000);
            return;
        end
        for (int n = 0; n < 20 && exec_valid_out !== 1'b1; n++) @(posedge core_clk_in);
        chk("engine req", 16'(exec_valid_out), 16'h0001);
        chk("action", exec_out.action, ac);
        chk("func", exec_out.func, fc);
        chk("class", 16'(exec_act_out), 16'(good_act[k]));
        foreach (good_ac[j]) begin
            @(posedge core_clk_in);
            param_addr_in <= (j == 0) ? 8'd2 : 8'd255 - 8'(j);
            @(posedge core_clk_in);
            @(posedge core_clk_in);
            #1 chk("param", param_data_out, host.word_of((j == 0) ? 2 : 255 - j, ac, fc));
        end
        @(posedge core_clk_in);
        exec_done_in <= 1'b1;
        exec_ok_in <= (k != 2);
        exec_xstat_in <= (k != 2) ? 16'h1234 : 16'hc006;
        exec_nsect_in <= ns;
        @(posedge core_clk_in);
        exec_done_in <= 1'b0;
        host.take_resp(r);
        chk_resp(k != 2, 16'hc006);
        chk("nsect", {r.lba_hi, r.lba_mid}, ns);
        chk("exec nsect", exec_out.nsect, ns);
        chk("exec xstat", exec_out.xstat, (k != 2) ? 16'h0000 : 16'hc006);
    endtask

    initial begin
        nrst_in = 1'b0;
        exec_done_in = 1'b0;
        exec_ok_in = 1'b0;
        exec_xstat_in = 16'h0000;
        exec_nsect_in = 16'h0000;
        param_addr_in = 8'h00;
        n_exec = 0;
        n_errors = 0;
        checks_done = 0;
        cycles = 0;
        repeat (3) @(posedge core_clk_in);
        #1 chk("reset ready", 16'({cmd_ready_out, pkt_ready_out}), 16'h0003);
        chk("reset idle", 16'({resp_valid_out, busy_out, exec_valid_out}), 16'h0000);
        @(posedge core_clk_in);
        nrst_in <= 1'b1;
        refusal(tf_of(`SCT_OP_WRLOGX, `SCT_CNT_CUR, `SCT_PAGE_DATA), `SCT_XS_NOCMD);
        refusal(tf_of(`SCT_OP_WRLOGX, 8'h02, `SCT_PAGE_CMD), `SCT_XS_BADCNT);
        host.send_cmd(tf_of(8'h2f, `SCT_CNT_CUR, `SCT_PAGE_CMD));
        repeat (3) @(posedge core_clk_in);
        #1 chk("other opcode", 16'({busy_out, resp_valid_out}), 16'h0000);
        foreach (good_ac[k]) run_cmd(good_ac[k], k, 1'b0);
        chk("armed", 16'(data_page_armed_out), 16'h0001);
        foreach (bad_ac[k]) run_cmd(bad_ac[k], k, 1'b1);
        end_of_test();
    end
endmodule
`default_nettype wire
